/* dv/cmf_framer_asserts.sv */
`timescale 1ns/1ps
module cmf_framer_asserts #(
  parameter int RX_TIMEOUT_CYC = 50,
  parameter int RSP_WAIT_CYC = 50
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic tx_ready_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic pay_valid_o,
  input wire logic [7:0] pay_data_o,
  input wire logic msg_done_o,
  input wire logic [2:0] msg_type_o,
  input wire logic msg_abort_o,
  input wire logic hdr_err_o,
  input wire logic rsp_wait_o,
  input wire logic rsp_valid_i,
  input wire logic unsol_taken_o,
  input wire logic unsol_valid_i,
  input wire logic dtx_valid_i
);
  // Cycles since the last received byte
  int idle;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || (ce_i && rx_valid_i))
      idle <= 0;
    else if (ce_i)
      idle <= idle + 1;
  end
  // Cycles with no frame that could hold the transmitter ahead of an answer
  int quiet;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || tx_valid_o || unsol_valid_i || dtx_valid_i ||
      (msg_done_o && msg_type_o[2]))
      quiet <= 0;
    else if (ce_i && quiet < 8)
      quiet <= quiet + 1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  tx_hold_a:
  assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("tx byte changed before it was accepted");
  pay_cause_a:
  assert property (pay_valid_o |-> $past(ce_i) && $past(rx_valid_i) &&
    pay_data_o == $past(rx_data_i))
    else $error("payload byte not the byte just received");
  done_cause_a:
  assert property (msg_done_o |-> $past(ce_i) && $past(rx_valid_i))
    else $error("message done without a final byte");
  err_cause_a:
  assert property (hdr_err_o |-> $past(ce_i) && $past(rx_valid_i))
    else $error("header error without a received byte");
  done_excl_a:
  assert property (!(msg_done_o && hdr_err_o))
    else $error("message both done and refused");
  abort_idle_a:
  assert property (msg_abort_o |-> idle >= RX_TIMEOUT_CYC - 1 && idle <= RX_TIMEOUT_CYC + 2)
    else $error("abort not at the idle limit");
  wait_rise_a:
  assert property ($rose(rsp_wait_o) |-> $past(msg_done_o) && $past(msg_type_o) <= 3'h2)
    else $error("answer wait without a control request");
  wait_drop_a:
  assert property (rsp_wait_o && rsp_valid_i && ce_i && !msg_done_o |=> !rsp_wait_o)
    else $error("answer wait stayed after capture");
  rsp_first_a:
  assert property (rsp_wait_o && rsp_valid_i && ce_i && !tx_valid_o && !unsol_valid_i &&
    !dtx_valid_i && quiet >= 3 |-> ##4 tx_valid_o)
    else $error("answer first byte late");
  unsol_tx_a:
  assert property (unsol_taken_o && ce_i |-> ##2 tx_valid_o)
    else $error("unsolicited report not sent");
endmodule // cmf_framer_asserts

bind cmf_framer cmf_framer_asserts #(
  .RX_TIMEOUT_CYC(RX_TIMEOUT_CYC),
  .RSP_WAIT_CYC(RSP_WAIT_CYC)
) chk_u (
  .clk_i, .rst_n_i, .ce_i, .rx_valid_i, .rx_data_i, .tx_ready_i, .tx_valid_o, .tx_data_o,
  .pay_valid_o, .pay_data_o, .msg_done_o, .msg_type_o, .msg_abort_o, .hdr_err_o,
  .rsp_wait_o, .rsp_valid_i, .unsol_taken_o, .unsol_valid_i, .dtx_valid_i
);

/* dv/cmf_framer_test.sv */
`timescale 1ns/1ps
module cmf_framer_test;
  localparam int TMO = 50;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic rx_valid_i, tx_ready_i, tx_valid_o, pay_valid_o, msg_done_o, msg_abort_o, hdr_err_o;
  logic [7:0] rx_data_i, tx_data_o, pay_data_o;
  logic [1:0] pay_ch_o;
  logic [2:0] msg_type_o;
  logic [15:0] msg_code_o;
  logic [13:0] msg_len_o;
  logic [31:0] msg_param_o;
  logic rsp_wait_o, unsol_taken_o, dtx_started_o, dtx_take_o;
  logic rsp_valid_i = 1'b0, rsp_ok_i = 1'b0, ack_en_i = 1'b0, unsol_valid_i = 1'b0;
  logic [2:0] rsp_nbytes_i = 3'h0, unsol_nbytes_i = 3'h0;
  logic [31:0] rsp_data_i = 32'h0, unsol_data_i = 32'h0;
  logic [15:0] unsol_code_i = 16'h0;
  logic dtx_valid_i = 1'b0;
  logic [1:0] dtx_ch_i = 2'h0;
  logic [12:0] dtx_len_i = 13'h0;
  logic [7:0] dtx_byte_i = 8'h00;
  logic [7:0] pay_q[$];
  int mismatches = 0, checks_done = 0, dones = 0, errs = 0, aborts = 0;

  cmf_framer #(.RX_TIMEOUT_CYC(TMO), .RSP_WAIT_CYC(TMO)) dut_u (.clk_i, .rst_n_i, .ce_i,
    .rx_valid_i, .rx_data_i, .tx_ready_i, .tx_valid_o, .tx_data_o, .pay_valid_o, .pay_data_o,
    .pay_ch_o, .msg_done_o, .msg_type_o, .msg_code_o, .msg_len_o, .msg_param_o, .msg_abort_o,
    .hdr_err_o, .rsp_wait_o, .rsp_valid_i, .rsp_ok_i, .rsp_nbytes_i, .rsp_data_i, .ack_en_i,
    .unsol_valid_i, .unsol_code_i, .unsol_nbytes_i, .unsol_data_i, .unsol_taken_o,
    .dtx_valid_i, .dtx_ch_i, .dtx_len_i, .dtx_byte_i, .dtx_started_o, .dtx_take_o);
  cmf_host_model host_u (.clk_i, .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
    .tx_ready_o(tx_ready_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o));

  always #10 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    if (pay_valid_o)
      pay_q.push_back(pay_data_o);
    dones <= dones + int'(msg_done_o);
    errs <= errs + int'(hdr_err_o);
    aborts <= aborts + int'(msg_abort_o);
    if (dtx_take_o)
      dtx_byte_i <= dtx_byte_i + 8'h01;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic expect_tx(input logic [7:0] e[$]);
    for (int i = 0; i < 400 && host_u.got_q.size() < e.size(); i++)
      @(negedge clk_i);
    chk("tx count", 32'(e.size()), 32'(host_u.got_q.size()));
    foreach (e[i])
      if (i < host_u.got_q.size())
        chk("tx byte", {24'h0, e[i]}, {24'h0, host_u.got_q[i]});
    host_u.got_q.delete();
  endtask

  task automatic t_req(input logic [7:0] m[$], input logic ok, input logic [2:0] nb,
    input logic [31:0] d, input logic [7:0] e[$]);
    int d0;
    d0 = dones;
    host_u.send_msg(m);
    for (int i = 0; i < 20 && rsp_wait_o !== 1'b1; i++)
      @(negedge clk_i);
    chk("done", 32'(d0 + 1), 32'(dones));
    chk("type", {29'h0, m[1][7:5]}, {29'h0, msg_type_o});
    chk("code", {16'h0, m[3], m[2]}, {16'h0, msg_code_o});
    chk("len", 32'(m.size()), {18'h0, msg_len_o});
    rsp_ok_i = ok;
    rsp_nbytes_i = nb;
    rsp_data_i = d;
    rsp_valid_i = 1'b1;
    @(negedge clk_i);
    rsp_valid_i = 1'b0;
    expect_tx(e);
  endtask

  // No answer from the item logic, with a freeze that must hold the wait count
  task automatic t_silent();
    host_u.send_msg('{8'h04, 8'h20, 8'h0A, 8'h00});
    @(negedge clk_i);
    ce_i = 1'b0;
    repeat (TMO * 2) @(negedge clk_i);
    chk("frozen wait", 32'h1, {31'h0, rsp_wait_o});
    ce_i = 1'b1;
    expect_tx('{8'h02, 8'h00});
  endtask

  task automatic t_data();
    pay_q.delete();
    ack_en_i = 1'b1;
    host_u.send_msg('{8'h05, 8'hC0, 8'hAA, 8'hBB, 8'hCC});
    repeat (2) @(negedge clk_i);
    chk("pay count", 32'h3, 32'(pay_q.size()));
    chk("pay bytes", 32'hAABBCC, {8'h0, pay_q[0], pay_q[1], pay_q[2]});
    chk("pay ch", 32'h2, {30'h0, pay_ch_o});
    chk("data type", 32'h6, {29'h0, msg_type_o});
    expect_tx('{8'h03, 8'h60, 8'h02});
    ack_en_i = 1'b0;
  endtask

  task automatic t_big();
    int d0;
    d0 = dones;
    pay_q.delete();
    host_u.send_msg('{8'h00, 8'hE0});
    for (int i = 0; i < 8192; i++)
      host_u.send(i[7:0]);
    repeat (2) @(negedge clk_i);
    chk("big count", 32'h2000, 32'(pay_q.size()));
    chk("big len", 32'h2002, {18'h0, msg_len_o});
    chk("big done", 32'(d0 + 1), 32'(dones));
  endtask

  task automatic t_err();
    int e0, d0, a0;
    e0 = errs;
    d0 = dones;
    a0 = aborts;
    host_u.send_msg('{8'h03, 8'h00});
    host_u.send_msg('{8'h03, 8'h60, 8'h05});
    @(negedge clk_i);
    chk("hdr err", 32'(e0 + 2), 32'(errs));
    host_u.send_msg('{8'h06, 8'h00, 8'h01});
    repeat (TMO + 10) @(negedge clk_i);
    chk("abort", 32'(a0 + 1), 32'(aborts));
    host_u.send_msg('{8'h02, 8'h80});
    @(negedge clk_i);
    chk("resync", 32'(d0 + 1), 32'(dones));
    chk("empty len", 32'h2, {18'h0, msg_len_o});
    chk("no tx", 32'h0, 32'(host_u.got_q.size()));
  endtask

  task automatic t_unsol();
    host_u.slow = 1'b1;
    unsol_code_i = 16'h1234;
    unsol_nbytes_i = 3'h1;
    unsol_data_i = 32'h55;
    unsol_valid_i = 1'b1;
    for (int i = 0; i < 50 && unsol_taken_o !== 1'b1; i++)
      @(negedge clk_i);
    unsol_valid_i = 1'b0;
    expect_tx('{8'h05, 8'h20, 8'h34, 8'h12, 8'h55});
    host_u.slow = 1'b0;
  endtask

  task automatic t_dtx();
    dtx_byte_i = 8'h5A;
    dtx_ch_i = 2'h1;
    dtx_len_i = 13'h0004;
    dtx_valid_i = 1'b1;
    for (int i = 0; i < 50 && dtx_started_o !== 1'b1; i++)
      @(negedge clk_i);
    dtx_valid_i = 1'b0;
    expect_tx('{8'h04, 8'hA0, 8'h5A, 8'h5B});
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #1000000;
    mismatches++;
    $display("mismatch watchdog expected finish seen hang");
    conclude();
  end

  initial
  begin
    repeat (4) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_req('{8'h04, 8'h20, 8'h05, 8'h00}, 1'b1, 3'h2, 32'h0211,
      '{8'h06, 8'h00, 8'h05, 8'h00, 8'h11, 8'h02});
    t_req('{8'h06, 8'h00, 8'h09, 8'h00, 8'hAB, 8'hCD}, 1'b1, 3'h6, 32'h44332211,
      '{8'h08, 8'h00, 8'h09, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44});
    chk("param", 32'hCDAB, {16'h0, msg_param_o[15:0]});
    t_req('{8'h04, 8'h40, 8'h07, 8'h00}, 1'b0, 3'h0, 32'h0,
      '{8'h02, 8'h40});
    t_silent();
    t_data();
    t_err();
    t_unsol();
    t_dtx();
    t_big();
    conclude();
  end
endmodule // cmf_framer_test

/* dv/cmf_host_model.sv */
`timescale 1ns/1ps
module cmf_host_model (
  input wire logic clk_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic tx_ready_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i
);
  logic [7:0] got_q[$];
  logic slow = 1'b0;
  int phase = 0;
  initial
  begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    tx_ready_o = 1'b1;
  end
  // A slow host accepts one byte in three, so held tx bytes get exercised
  always @(negedge clk_i)
  begin
    phase <= (phase + 1) % 3;
    tx_ready_o <= !slow || phase == 0;
  end
  always @(posedge clk_i)
    if (tx_valid_i && tx_ready_o)
      got_q.push_back(tx_data_i);
  // Bytes are pushed with no back-pressure; idle data lines carry the inverse
  task automatic send(input logic [7:0] b);
    @(negedge clk_i);
    rx_valid_o = 1'b1;
    rx_data_o = b;
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_data_o = ~b;
  endtask
  // Caller gives header low byte first and only host type codes
  task automatic send_msg(input logic [7:0] m[$]);
    foreach (m[i])
      send(m[i]);
  endtask
endmodule // cmf_host_model

/* rtl/cmf_framer.sv */
`timescale 1ns/1ps
module cmf_framer #(
  parameter int RX_TIMEOUT_CYC = cmf_pkg::TIMEOUT_CYC,
  parameter int RSP_WAIT_CYC = cmf_pkg::TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic tx_ready_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic pay_valid_o,
  output logic [7:0] pay_data_o,
  output logic [1:0] pay_ch_o,
  output logic msg_done_o,
  output logic [2:0] msg_type_o,
  output logic [15:0] msg_code_o,
  output logic [13:0] msg_len_o,
  output logic [31:0] msg_param_o,
  output logic msg_abort_o,
  output logic hdr_err_o,
  output logic rsp_wait_o,
  input wire logic rsp_valid_i,
  input wire logic rsp_ok_i,
  input wire logic [2:0] rsp_nbytes_i,
  input wire logic [31:0] rsp_data_i,
  input wire logic ack_en_i,
  input wire logic unsol_valid_i,
  input wire logic [15:0] unsol_code_i,
  input wire logic [2:0] unsol_nbytes_i,
  input wire logic [31:0] unsol_data_i,
  output logic unsol_taken_o,
  input wire logic dtx_valid_i,
  input wire logic [1:0] dtx_ch_i,
  input wire logic [12:0] dtx_len_i,
  input wire logic [7:0] dtx_byte_i,
  output logic dtx_started_o,
  output logic dtx_take_o
);
  typedef enum {RX_LO, RX_HI, RX_BODY} cmf_rx_state_t;

  localparam logic [cmf_pkg::CNT_W-1:0] RX_LIMIT = cmf_pkg::CNT_W'(RX_TIMEOUT_CYC);
  localparam logic [cmf_pkg::CNT_W-1:0] RSP_LIMIT = cmf_pkg::CNT_W'(RSP_WAIT_CYC);

  // Total byte count of a reply, its parameter bytes capped at what the head buffer holds
  function automatic logic [13:0] cmf_reply_total(input logic [2:0] n);
    cmf_reply_total = cmf_pkg::CODE_END + ((n > cmf_pkg::PARAM_MAX) ?
      {11'h000, cmf_pkg::PARAM_MAX} : {11'h000, n});
  endfunction

  cmf_tx_if tx ();

  cmf_tx_ser u_ser (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .tx(tx.ser),
    .tx_ready_i(tx_ready_i),
    .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o)
  );

  // Receive side state
  cmf_rx_state_t rx_state;
  logic [7:0] len_lo;
  logic [2:0] typ;
  logic [13:0] total;
  logic [13:0] idx;
  logic [15:0] code;
  logic [31:0] params;
  logic [cmf_pkg::CNT_W-1:0] gap_cnt;
  logic rx_req;
  logic rx_dat_done;

  // Header decode, host direction meanings
  wire [2:0] hi_type = rx_data_i[7:5];
  wire [12:0] hi_len = {rx_data_i[4:0], len_lo};
  wire hi_is_data = hi_type[cmf_pkg::DATA_BIT];
  wire hi_is_ctl = hi_type < cmf_pkg::HT_ACK;
  wire [13:0] hi_total = cmf_pkg::cmf_total(hi_len, hi_is_data);
  // A length that does not fit the type (too short, or for an acknowledge other than three) cannot be a real header; drop it and hunt again
  wire hi_sane = hi_is_data ? (hi_total >= cmf_pkg::HDR_BYTES) :
    hi_is_ctl ? (hi_total >= cmf_pkg::CODE_END) :
    (hi_total == cmf_pkg::ACK_TOTAL);

  wire is_data = typ[cmf_pkg::DATA_BIT];
  wire is_ctl = typ < cmf_pkg::HT_ACK;
  wire is_ack = typ == cmf_pkg::HT_ACK;
  wire last = idx == (total - 14'h0001);
  wire [13:0] slot = is_ctl ? (idx - cmf_pkg::CODE_END) : (idx - cmf_pkg::HDR_BYTES);
  wire slot_hit = !is_data && (!is_ctl || idx >= cmf_pkg::CODE_END) &&
    slot < cmf_pkg::PARAM_BYTES;
  wire [4:0] slot_sh = {slot[1:0], 3'h0};
  wire [31:0] next_params = slot_hit ?
    ((params & ~(32'h000000FF << slot_sh)) | ({24'h000000, rx_data_i} << slot_sh)) :
    params;
  wire [15:0] next_code = (idx == cmf_pkg::CODE_HI_IDX) ?
    {rx_data_i, code[7:0]} : code;
  wire ack_bad = is_ack && rx_data_i > cmf_pkg::MAX_CH;
  wire rx_late = rx_state != RX_LO && gap_cnt >= RX_LIMIT;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      gap_cnt <= '0;
    else if (ce_i)
      gap_cnt <= (rx_valid_i || rx_state == RX_LO) ? '0 :
        gap_cnt + cmf_pkg::CNT_W'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rx_state <= RX_LO;
      len_lo <= 8'h00;
      typ <= 3'h0;
      total <= 14'h0000;
      idx <= 14'h0000;
      code <= 16'h0000;
      params <= 32'h00000000;
      rx_req <= 1'b0;
      rx_dat_done <= 1'b0;
      pay_valid_o <= 1'b0;
      pay_data_o <= 8'h00;
      pay_ch_o <= 2'h0;
      msg_done_o <= 1'b0;
      msg_type_o <= 3'h0;
      msg_code_o <= 16'h0000;
      msg_len_o <= 14'h0000;
      msg_param_o <= 32'h00000000;
      msg_abort_o <= 1'b0;
      hdr_err_o <= 1'b0;
    end
    else if (ce_i)
    begin
      pay_valid_o <= 1'b0;
      msg_done_o <= 1'b0;
      msg_abort_o <= 1'b0;
      hdr_err_o <= 1'b0;
      rx_req <= 1'b0;
      rx_dat_done <= 1'b0;
      if (rx_late)
      begin
        rx_state <= RX_LO;
        msg_abort_o <= 1'b1;
      end
      else if (rx_valid_i)
      begin
        case (rx_state)
          RX_LO:
          begin
            len_lo <= rx_data_i;
            rx_state <= RX_HI;
          end
          RX_HI:
          begin
            typ <= hi_type;
            total <= hi_total;
            idx <= cmf_pkg::HDR_BYTES;
            code <= 16'h0000;
            params <= 32'h00000000;
            if (!hi_sane)
            begin
              // Only a plausibility check; true recovery is left to the link
              hdr_err_o <= 1'b1;
              rx_state <= RX_LO;
            end
            else if (hi_total == cmf_pkg::HDR_BYTES)
            begin
              // Empty data message is complete with its header
              msg_done_o <= 1'b1;
              msg_type_o <= hi_type;
              msg_len_o <= hi_total;
              msg_code_o <= 16'h0000;
              msg_param_o <= 32'h00000000;
              rx_dat_done <= 1'b1;
              rx_state <= RX_LO;
            end
            else
              rx_state <= RX_BODY;
          end
          RX_BODY:
          begin
            idx <= idx + 14'h0001;
            params <= next_params;
            if (is_ctl && idx == cmf_pkg::HDR_BYTES)
              code[7:0] <= rx_data_i;
            if (is_ctl && idx == cmf_pkg::CODE_HI_IDX)
              code[15:8] <= rx_data_i;
            if (is_data)
            begin
              pay_valid_o <= 1'b1;
              pay_data_o <= rx_data_i;
              pay_ch_o <= typ[1:0];
            end
            if (last)
            begin
              rx_state <= RX_LO;
              if (ack_bad)
                hdr_err_o <= 1'b1;
              else
              begin
                msg_done_o <= 1'b1;
                msg_type_o <= typ;
                msg_len_o <= total;
                msg_code_o <= is_ctl ? next_code : 16'h0000;
                msg_param_o <= next_params;
                rx_req <= is_ctl;
                rx_dat_done <= is_data;
              end
            end
          end
          default:
            rx_state <= RX_LO;
        endcase
      end
    end
  end

  // Transmit side state
  logic [cmf_pkg::CNT_W-1:0] wait_cnt;
  logic [15:0] pend_code;
  logic [2:0] pend_rtype;
  logic ans;
  logic ans_ok;
  logic [2:0] ans_n;
  logic [31:0] ans_data;
  logic [15:0] ans_code;
  logic [2:0] ans_rtype;
  logic ack_pend;
  logic [1:0] ack_ch;

  wire rsp_late = rsp_wait_o && wait_cnt >= RSP_LIMIT;
  wire can_issue = !tx.busy && !tx.start;
  // Range requests get range answers, set and get share the plain answer
  wire [2:0] req_rtype = (msg_type_o == cmf_pkg::HT_RANGE) ?
    cmf_pkg::TT_RANGE : cmf_pkg::TT_RSP;

  // A rejection is the bare header of the answer type
  wire [13:0] rsp_total = ans_ok ? cmf_reply_total(ans_n) :
    cmf_pkg::HDR_BYTES;
  wire [63:0] rsp_head = {ans_data, ans_code,
    cmf_pkg::cmf_hdr(rsp_total[12:0], ans_rtype)};
  wire [13:0] ack_total = cmf_pkg::ACK_TOTAL;
  wire [63:0] ack_head = {40'h0000000000, 6'h00, ack_ch,
    cmf_pkg::cmf_hdr(ack_total[12:0], cmf_pkg::TT_ACK)};
  wire [13:0] unsol_total = cmf_reply_total(unsol_nbytes_i);
  wire [63:0] unsol_head = {unsol_data_i, unsol_code_i,
    cmf_pkg::cmf_hdr(unsol_total[12:0], cmf_pkg::TT_UNSOL)};
  wire [2:0] dtx_type = {1'b1, dtx_ch_i};
  wire [13:0] dtx_total = cmf_pkg::cmf_total(dtx_len_i, 1'b1);
  wire [63:0] dtx_head = {48'h000000000000, cmf_pkg::cmf_hdr(dtx_len_i, dtx_type)};

  // Fixed priority: answers first so a waiting host is never starved
  wire have = ans || ack_pend || unsol_valid_i || dtx_valid_i;
  wire [13:0] sel_total = ans ? rsp_total : ack_pend ? ack_total :
    unsol_valid_i ? unsol_total : dtx_total;
  wire [63:0] sel_head = ans ? rsp_head : ack_pend ? ack_head :
    unsol_valid_i ? unsol_head : dtx_head;
  wire [3:0] sel_n = (ans || ack_pend || unsol_valid_i) ? sel_total[3:0] :
    cmf_pkg::DATA_HEAD_N;

  assign tx.ext_byte = dtx_byte_i;
  assign dtx_take_o = tx.ext_take;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      wait_cnt <= '0;
    else if (ce_i)
      wait_cnt <= (rx_req || !rsp_wait_o) ? '0 : wait_cnt + cmf_pkg::CNT_W'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rsp_wait_o <= 1'b0;
      pend_code <= 16'h0000;
      pend_rtype <= 3'h0;
      ans <= 1'b0;
      ans_ok <= 1'b0;
      ans_n <= 3'h0;
      ans_data <= 32'h00000000;
      ans_code <= 16'h0000;
      ans_rtype <= 3'h0;
      ack_pend <= 1'b0;
      ack_ch <= 2'h0;
      tx.start <= 1'b0;
      tx.total <= 14'h0000;
      tx.head_n <= 4'h0;
      tx.head <= 64'h0;
      unsol_taken_o <= 1'b0;
      dtx_started_o <= 1'b0;
    end
    else if (ce_i)
    begin
      tx.start <= 1'b0;
      unsol_taken_o <= 1'b0;
      dtx_started_o <= 1'b0;
      if (can_issue && have)
      begin
        tx.start <= 1'b1;
        tx.total <= sel_total;
        tx.head_n <= sel_n;
        tx.head <= sel_head;
        if (ans)
          ans <= 1'b0;
        else if (ack_pend)
          ack_pend <= 1'b0;
        else if (unsol_valid_i)
          unsol_taken_o <= 1'b1;
        else
          dtx_started_o <= 1'b1;
      end
      // Capture after the issue clear so a new answer is never lost
      if (rsp_wait_o && (rsp_valid_i || rsp_late))
      begin
        // Silence from the item logic turns into a rejection
        rsp_wait_o <= 1'b0;
        ans <= 1'b1;
        ans_ok <= rsp_valid_i && rsp_ok_i;
        ans_n <= rsp_nbytes_i;
        ans_data <= rsp_valid_i ? rsp_data_i : 32'h00000000;
        ans_code <= pend_code;
        ans_rtype <= pend_rtype;
      end
      // New events after the clears so a same-cycle arrival is kept
      if (rx_req)
      begin
        rsp_wait_o <= 1'b1;
        pend_code <= msg_code_o;
        pend_rtype <= req_rtype;
      end
      if (rx_dat_done && ack_en_i)
      begin
        ack_pend <= 1'b1;
        ack_ch <= msg_type_o[1:0];
      end
    end
  end
endmodule // cmf_framer

/* rtl/cmf_pkg.sv */
package cmf_pkg;
  // Link pacing: one byte on the wire is start, eight data bits and stop
  localparam int CLK_HZ = 50000000;
  localparam int LINK_BAUD = 230400;
  localparam int BITS_PER_BYTE = 10;
  localparam int BYTE_CYC = (CLK_HZ / LINK_BAUD) * BITS_PER_BYTE;
  // Idle time, in byte times, before a partial message or a pending answer is given up
  localparam int TIMEOUT_BYTES = 256;
  localparam int TIMEOUT_CYC = TIMEOUT_BYTES * BYTE_CYC;
  localparam int CNT_W = 20;

  // Message type codes, host to target
  localparam logic [2:0] HT_SET = 3'h0;
  localparam logic [2:0] HT_GET = 3'h1;
  localparam logic [2:0] HT_RANGE = 3'h2;
  localparam logic [2:0] HT_ACK = 3'h3;
  // Message type codes, target to host
  localparam logic [2:0] TT_RSP = 3'h0;
  localparam logic [2:0] TT_UNSOL = 3'h1;
  localparam logic [2:0] TT_RANGE = 3'h2;
  localparam logic [2:0] TT_ACK = 3'h3;
  // Type bit that marks a data channel message, the rest is the channel
  localparam int DATA_BIT = 2;

  // Byte positions and sizes
  localparam logic [13:0] HDR_BYTES = 14'h0002;
  localparam logic [13:0] CODE_HI_IDX = 14'h0003;
  localparam logic [13:0] CODE_END = 14'h0004;
  localparam logic [13:0] ACK_TOTAL = 14'h0003;
  localparam logic [13:0] PARAM_BYTES = 14'h0004;
  localparam logic [13:0] DATA_MAX_TOTAL = 14'h2002;
  localparam logic [2:0] PARAM_MAX = 3'h4;
  localparam logic [7:0] MAX_CH = 8'h03;
  localparam logic [3:0] DATA_HEAD_N = 4'h2;

  // Total bytes of a message from its length field
  function automatic logic [13:0] cmf_total(input logic [12:0] len, input logic is_data);
    cmf_total = (is_data && len == 13'h0000) ? DATA_MAX_TOTAL : {1'b0, len};
  endfunction

  // Header word; low byte goes first on the link
  function automatic logic [15:0] cmf_hdr(input logic [12:0] len, input logic [2:0] typ);
    cmf_hdr = {typ, len[12:8], len[7:0]};
  endfunction
endpackage

/* rtl/cmf_tx_if.sv */
`timescale 1ns/1ps
interface cmf_tx_if;
  logic start;
  logic [13:0] total;
  logic [3:0] head_n;
  logic [63:0] head;
  logic [7:0] ext_byte;
  logic busy;
  logic ext_take;
  modport ctl (output start, total, head_n, head, ext_byte, input busy, ext_take);
  modport ser (input start, total, head_n, head, ext_byte, output busy, ext_take);
endinterface

/* rtl/cmf_tx_ser.sv */
`timescale 1ns/1ps
module cmf_tx_ser (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  cmf_tx_if.ser tx,
  input wire logic tx_ready_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o
);
  logic [63:0] head;
  logic [13:0] total;
  logic [13:0] cnt;
  logic [3:0] head_n;
  logic gap;

  // The gap after a streamed byte gives the source one cycle to present the next
  wire advance = tx.busy && !gap && (!tx_valid_o || tx_ready_i);
  wire more = cnt < total;
  wire from_head = cnt < {10'h000, head_n};
  wire [7:0] head_byte = head[{cnt[2:0], 3'h0} +: 8];

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      tx.busy <= 1'b0;
      tx.ext_take <= 1'b0;
      head <= 64'h0;
      total <= 14'h0000;
      cnt <= 14'h0000;
      head_n <= 4'h0;
      gap <= 1'b0;
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
    end
    else if (ce_i)
    begin
      tx.ext_take <= 1'b0;
      gap <= 1'b0;
      if (tx_valid_o && tx_ready_i)
        tx_valid_o <= 1'b0;
      if (!tx.busy)
      begin
        if (tx.start)
        begin
          tx.busy <= 1'b1;
          head <= tx.head;
          total <= tx.total;
          head_n <= tx.head_n;
          cnt <= 14'h0000;
        end
      end
      else if (advance)
      begin
        if (more)
        begin
          tx_valid_o <= 1'b1;
          tx_data_o <= from_head ? head_byte : tx.ext_byte;
          cnt <= cnt + 14'h0001;
          if (!from_head)
          begin
            tx.ext_take <= 1'b1;
            gap <= 1'b1;
          end
        end
        else
          tx.busy <= 1'b0;
      end
    end
  end
endmodule // cmf_tx_ser
